// ==== verilog/eic_pkg.sv ====
// constants and types shared by the external pin interrupt controller
// assumes a single 100 MHz clock and an apb master with 32-bit data
package eic_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_IRQ = 3;
  localparam int VEC_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_GENERAL_IRQ_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MCU_GENERAL_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MCU_CONTROL_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS_REGISTER = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVENT_ENABLE = 8'h18;

  // field positions
  localparam int MCU_GENERAL_CONTROL_SENSE_ONE_LSB = 2;
  localparam int MCU_GENERAL_CONTROL_SENSE_ZERO_LSB = 0;
  localparam int MCU_CONTROL_STATUS_EDGE_POL_BIT = 6;
  localparam int STATUS_REGISTER_GLOBAL_EN_BIT = 7;

  // reset values
  localparam logic [7:0] GENERAL_IRQ_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MCU_GENERAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MCU_CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
  localparam logic [2:0] EVENT_EN_RESET = 3'h0;

  // vector change sequence timing, in clock cycles
  localparam int CHANGE_WINDOW_CYCLES = 4;
  localparam int POST_WRITE_CYCLES = 1;
  localparam int CNT_W = 3;

  typedef enum logic [1:0] {
    EIC_SENSE_LOW,
    EIC_SENSE_ANY,
    EIC_SENSE_FALL,
    EIC_SENSE_RISE
  } eic_sense_t;

  typedef enum logic [1:0] {
    EIC_CHG_IDLE,
    EIC_CHG_OPEN,
    EIC_CHG_HOLD
  } eic_chg_state_t;

  typedef struct packed {
    logic en_one;
    logic en_zero;
    logic en_two;
    logic [2:0] reserved;
    logic vector_table_select;
    logic vector_change_enable;
  } eic_general_irq_control_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [31:0] wdata;
  } eic_apb_req_t;

endpackage

// ==== verilog/eic_sense.sv ====
// one pin's sampler and trigger detector
// assumes the pin is already synchronous to the clock
module eic_sense
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  input wire eic_pkg::eic_sense_t mode,
  output logic event_hit,
  output logic level_mode
);

  logic sampled;
  logic previous;

  // pin is registered before any edge detection so a pulse wider than a period is always seen
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sampled <= 1'b1;
      previous <= 1'b1;
    end
    else
    begin
      sampled <= pin;
      previous <= sampled;
    end
  end

  assign level_mode = (mode == eic_pkg::EIC_SENSE_LOW);

  always_comb
  begin
    event_hit = 1'b0;
    unique case (mode)
      eic_pkg::EIC_SENSE_LOW: event_hit = ~sampled;
      eic_pkg::EIC_SENSE_ANY: event_hit = sampled ^ previous;
      eic_pkg::EIC_SENSE_FALL: event_hit = previous & ~sampled;
      eic_pkg::EIC_SENSE_RISE: event_hit = ~previous & sampled;
    endcase
  end

endmodule

// ==== verilog/eic_top.sv ====
// external pin interrupt controller: enables, sense control, vector table select
// assumes an apb master on the same clock and a cpu that acknowledges taken requests
module eic_top
#(
  parameter logic [15:0] BOOT_BASE_0 = 16'h1000,
  parameter logic [15:0] BOOT_BASE_1 = 16'h2000,
  parameter logic [15:0] BOOT_BASE_2 = 16'h3000,
  parameter logic [15:0] BOOT_BASE_3 = 16'h3800,
  parameter logic [15:0] VECTOR_STEP = 16'h0002
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [eic_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [eic_pkg::NUM_IRQ-1:0] EXT_IRQ_PIN,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic [eic_pkg::NUM_IRQ-1:0] IRQ_ACK,
  output logic [eic_pkg::NUM_IRQ-1:0] EXT_IRQ_REQ,
  output logic [eic_pkg::VEC_W-1:0] IRQ_VECTOR,
  output logic [eic_pkg::VEC_W-1:0] VECTOR_BASE,
  output logic IRQ
);

  eic_pkg::eic_general_irq_control_t general_irq_control;
  logic en_one;
  logic en_zero;
  logic en_two;
  logic table_select;
  logic [7:0] mcu_general_control;
  logic [7:0] mcu_control_status;
  logic [7:0] status_register;
  logic [2:0] event_status;
  logic [2:0] event_enable;
  logic [2:0] pending;
  eic_pkg::eic_chg_state_t chg_state;
  logic [eic_pkg::CNT_W-1:0] chg_count;
  eic_pkg::eic_apb_req_t req;
  logic access;
  logic wr_general_irq_control;
  logic vector_change_enable_set_write;
  logic vector_table_select_accept;
  logic seq_mask;
  logic [2:0] event_hit;
  logic [2:0] level_mode;
  eic_pkg::eic_sense_t sense [3];
  logic [2:0] enable_vec;
  logic [2:0] next_req;

  assign req.addr = PADDR;
  assign req.write = PWRITE;
  assign req.wdata = PWDATA;
  assign access = PSEL & PENABLE & PREADY;

  function automatic logic hit(input logic [eic_pkg::ADDR_W-1:0] a, input logic [eic_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [eic_pkg::ADDR_W-1:0] a);
    mapped = hit(a, eic_pkg::OFS_GENERAL_IRQ_CONTROL) | hit(a, eic_pkg::OFS_MCU_GENERAL_CONTROL)
           | hit(a, eic_pkg::OFS_MCU_CONTROL_STATUS) | hit(a, eic_pkg::OFS_STATUS_REGISTER)
           | hit(a, eic_pkg::OFS_EVENT_STATUS) | hit(a, eic_pkg::OFS_EVENT_CLEAR)
           | hit(a, eic_pkg::OFS_EVENT_ENABLE);
  endfunction

  assign wr_general_irq_control = access & req.write & hit(req.addr, eic_pkg::OFS_GENERAL_IRQ_CONTROL);
  assign vector_change_enable_set_write = wr_general_irq_control & req.wdata[0];
  assign vector_table_select_accept = wr_general_irq_control & ~req.wdata[0] & (chg_state == eic_pkg::EIC_CHG_OPEN);
  // mask from the set cycle on
  assign seq_mask = vector_change_enable_set_write | (chg_state != eic_pkg::EIC_CHG_IDLE);

  // apb: one setup cycle, answer in the first access cycle
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped(req.addr);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      PRDATA <= 32'h0000_0000;
    end
    else if (PSEL & ~PENABLE & ~req.write)
    begin
      PRDATA <= 32'h0000_0000;
      if (hit(req.addr, eic_pkg::OFS_GENERAL_IRQ_CONTROL))
      begin
        PRDATA[7:0] <= {general_irq_control.en_one, general_irq_control.en_zero, general_irq_control.en_two, 3'b000,
                        general_irq_control.vector_table_select, chg_state == eic_pkg::EIC_CHG_OPEN};
      end
      if (hit(req.addr, eic_pkg::OFS_MCU_GENERAL_CONTROL))
      begin
        PRDATA[7:0] <= mcu_general_control;
      end
      if (hit(req.addr, eic_pkg::OFS_MCU_CONTROL_STATUS))
      begin
        PRDATA[7:0] <= mcu_control_status;
      end
      if (hit(req.addr, eic_pkg::OFS_STATUS_REGISTER))
      begin
        PRDATA[7:0] <= status_register;
      end
      if (hit(req.addr, eic_pkg::OFS_EVENT_STATUS))
      begin
        PRDATA[2:0] <= event_status;
      end
      if (hit(req.addr, eic_pkg::OFS_EVENT_ENABLE))
      begin
        PRDATA[2:0] <= event_enable;
      end
    end
  end

  // enable bits; select and change enable are kept by the sequence logic
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      en_one <= eic_pkg::GENERAL_IRQ_CONTROL_RESET[7];
      en_zero <= eic_pkg::GENERAL_IRQ_CONTROL_RESET[6];
      en_two <= eic_pkg::GENERAL_IRQ_CONTROL_RESET[5];
    end
    else if (wr_general_irq_control)
    begin
      en_one <= req.wdata[7];
      en_zero <= req.wdata[6];
      en_two <= req.wdata[5];
    end
  end
  // one driver for the whole struct; the enables keep their flops above, select and change enable come from the sequence logic, reserved is zero
  assign general_irq_control = '{en_one: en_one,
                  en_zero: en_zero,
                  en_two: en_two,
                  reserved: 3'b000,
                  vector_table_select: table_select,
                  vector_change_enable: (chg_state == eic_pkg::EIC_CHG_OPEN)};

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      mcu_general_control <= eic_pkg::MCU_GENERAL_CONTROL_RESET;
      mcu_control_status <= eic_pkg::MCU_CONTROL_STATUS_RESET;
      status_register <= eic_pkg::STATUS_REGISTER_RESET;
      event_enable <= eic_pkg::EVENT_EN_RESET;
    end
    else if (access & req.write)
    begin
      if (hit(req.addr, eic_pkg::OFS_MCU_GENERAL_CONTROL))
      begin
        mcu_general_control <= req.wdata[7:0];
      end
      if (hit(req.addr, eic_pkg::OFS_MCU_CONTROL_STATUS))
      begin
        mcu_control_status <= req.wdata[7:0] & (8'h01 << eic_pkg::MCU_CONTROL_STATUS_EDGE_POL_BIT);
      end
      if (hit(req.addr, eic_pkg::OFS_STATUS_REGISTER))
      begin
        status_register <= req.wdata[7:0] & (8'h01 << eic_pkg::STATUS_REGISTER_GLOBAL_EN_BIT);
      end
      if (hit(req.addr, eic_pkg::OFS_EVENT_ENABLE))
      begin
        event_enable <= req.wdata[2:0];
      end
    end
  end

  // vector change sequence
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      chg_state <= eic_pkg::EIC_CHG_IDLE;
      chg_count <= '0;
      table_select <= eic_pkg::GENERAL_IRQ_CONTROL_RESET[1];
    end
    else if (vector_change_enable_set_write)
    begin
      // a second set restarts the window
      chg_state <= eic_pkg::EIC_CHG_OPEN;
      chg_count <= eic_pkg::CNT_W'(eic_pkg::CHANGE_WINDOW_CYCLES - 1);
    end
    else
    begin
      unique case (chg_state)
        eic_pkg::EIC_CHG_IDLE:
        begin
          chg_count <= '0;
        end
        eic_pkg::EIC_CHG_OPEN:
        begin
          if (vector_table_select_accept)
          begin
            table_select <= req.wdata[1];
            chg_state <= eic_pkg::EIC_CHG_HOLD;
            chg_count <= eic_pkg::CNT_W'(eic_pkg::POST_WRITE_CYCLES - 1);
          end
          else if (chg_count == '0)
          begin
            chg_state <= eic_pkg::EIC_CHG_IDLE;
          end
          else
          begin
            chg_count <= chg_count - 1'b1;
          end
        end
        eic_pkg::EIC_CHG_HOLD:
        begin
          if (chg_count == '0)
          begin
            chg_state <= eic_pkg::EIC_CHG_IDLE;
          end
          else
          begin
            chg_count <= chg_count - 1'b1;
          end
        end
        // the fourth code of the state word is never entered
        default:
        begin
          chg_state <= eic_pkg::EIC_CHG_IDLE;
        end
      endcase
    end
  end

  assign sense[1] = eic_pkg::eic_sense_t'(mcu_general_control[eic_pkg::MCU_GENERAL_CONTROL_SENSE_ONE_LSB +: 2]);
  // request zero own pair, same encoding
  assign sense[0] = eic_pkg::eic_sense_t'(mcu_general_control[eic_pkg::MCU_GENERAL_CONTROL_SENSE_ZERO_LSB +: 2]);
  assign sense[2] = mcu_control_status[eic_pkg::MCU_CONTROL_STATUS_EDGE_POL_BIT] ? eic_pkg::EIC_SENSE_RISE
                                                                    : eic_pkg::EIC_SENSE_FALL;

  // pins sampled with no regard to port direction
  genvar gi;
  generate
    for (gi = 0; gi < eic_pkg::NUM_IRQ; gi++)
    begin : g_pin
      eic_sense u_sense
      (
        .clk(CLOCK),
        .reset(RESET),
        .pin(EXT_IRQ_PIN[gi]),
        .mode(sense[gi]),
        .event_hit(event_hit[gi]),
        .level_mode(level_mode[gi])
      );
    end
  endgenerate

  // edge requests latch until the cpu takes them; an event in the ack cycle wins
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pending <= 3'b000;
    end
    else
    begin
      pending <= ((pending & ~IRQ_ACK) | event_hit) & ~level_mode;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      event_status <= 3'b000;
    end
    else if (access & req.write & hit(req.addr, eic_pkg::OFS_EVENT_CLEAR))
    begin
      event_status <= (event_status & ~req.wdata[2:0]) | event_hit;
    end
    else
    begin
      event_status <= event_status | event_hit;
    end
  end

  assign enable_vec = {general_irq_control.en_two, general_irq_control.en_one, general_irq_control.en_zero};

  always_comb
  begin
    for (int i = 0; i < eic_pkg::NUM_IRQ; i++)
    begin
      // enable and global flag; masked without touching the flag
      // level mode is live, so a short low may be missed
      next_req[i] = enable_vec[i] & status_register[eic_pkg::STATUS_REGISTER_GLOBAL_EN_BIT] & ~seq_mask
                  & (level_mode[i] ? event_hit[i] : (pending[i] | event_hit[i]));
    end
  end

  function automatic logic [eic_pkg::VEC_W-1:0] boot_base(input logic [1:0] f);
    unique case (f)
      2'b00: boot_base = BOOT_BASE_0;
      2'b01: boot_base = BOOT_BASE_1;
      2'b10: boot_base = BOOT_BASE_2;
      2'b11: boot_base = BOOT_BASE_3;
    endcase
  endfunction

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      EXT_IRQ_REQ <= 3'b000;
      VECTOR_BASE <= 16'h0000;
      IRQ_VECTOR <= 16'h0000;
      IRQ <= 1'b0;
    end
    else
    begin
      EXT_IRQ_REQ <= next_req;
      VECTOR_BASE <= general_irq_control.vector_table_select ? boot_base(BOOT_SIZE_FUSES) : 16'h0000;
      // own entry per request, zero has priority
      if (next_req[0])
      begin
        IRQ_VECTOR <= (general_irq_control.vector_table_select ? boot_base(BOOT_SIZE_FUSES) : 16'h0000) + VECTOR_STEP;
      end
      else if (next_req[1])
      begin
        IRQ_VECTOR <= (general_irq_control.vector_table_select ? boot_base(BOOT_SIZE_FUSES) : 16'h0000) + 16'(VECTOR_STEP * 2);
      end
      else if (next_req[2])
      begin
        IRQ_VECTOR <= (general_irq_control.vector_table_select ? boot_base(BOOT_SIZE_FUSES) : 16'h0000) + 16'(VECTOR_STEP * 3);
      end
      else
      begin
        IRQ_VECTOR <= 16'h0000;
      end
      IRQ <= |(event_status & event_enable);
    end
  end

endmodule

// ==== verification/eic_pin_src.sv ====
// source model for the three external interrupt pins
// assumes the bench calls drive from its own sequence
module eic_pin_src
(
  input wire logic clk,
  output logic [2:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    pin = 3'h7;
  end
  // level held span
  // the caller picks the hold; a level source must outlast the instruction
  task automatic drive(input int i, input logic v, input int hold);
    @(posedge clk);
    pin[i] <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// ==== verification/eic_top_props.sv ====
// port assertions for the external pin interrupt controller
// assumes binding to eic_top; sees only its ports
module eic_top_props
#(
  parameter logic [15:0] BOOT_BASE_0 = 16'h1000,
  parameter logic [15:0] BOOT_BASE_1 = 16'h2000,
  parameter logic [15:0] BOOT_BASE_2 = 16'h3000,
  parameter logic [15:0] BOOT_BASE_3 = 16'h3800
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [eic_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic [eic_pkg::NUM_IRQ-1:0] EXT_IRQ_REQ,
  input wire logic [eic_pkg::VEC_W-1:0] VECTOR_BASE
);
  localparam logic [15:0] BASES [4] = '{BOOT_BASE_0, BOOT_BASE_1, BOOT_BASE_2, BOOT_BASE_3};
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  sequence s_change_set;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[0];
  endsequence
  sequence s_masked;
    (EXT_IRQ_REQ == 3'h0) [*3];
  endsequence
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing in access cycle");
  a_ready_only_access: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without setup");
  a_err_unmapped: assert property (PSEL && !PENABLE && PADDR > 8'h18 |=> PSLVERR && PREADY)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (PSEL && !PENABLE && PADDR <= 8'h18 && PADDR[1:0] == 2'h0 |=> !PSLVERR)
    else $error("mapped access refused");
  a_reserved_zero: assert property (PREADY && !PWRITE && PADDR == 8'h00 |-> PRDATA[4:2] == 3'h0)
    else $error("reserved bits not zero");
  a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_change_mask: assert property (s_change_set |=> s_masked)
    else $error("request during vector change");
  a_base_fuse: assert property (VECTOR_BASE != 16'h0000 |-> VECTOR_BASE == BASES[$past(BOOT_SIZE_FUSES)])
    else $error("vector base not boot base");
endmodule
bind eic_top eic_top_props #(
  .BOOT_BASE_0(BOOT_BASE_0),
  .BOOT_BASE_1(BOOT_BASE_1),
  .BOOT_BASE_2(BOOT_BASE_2),
  .BOOT_BASE_3(BOOT_BASE_3)
) u_props (
  .CLOCK(CLOCK),
  .RESET(RESET),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .BOOT_SIZE_FUSES(BOOT_SIZE_FUSES),
  .EXT_IRQ_REQ(EXT_IRQ_REQ),
  .VECTOR_BASE(VECTOR_BASE)
);

// ==== verification/eic_tb_top.sv ====
// self-checking bench for the external pin interrupt controller
// assumes eic_top, its bound checker and the pin source model
module eic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BB0 = 16'h1000;
  localparam logic [15:0] BB2 = 16'h3000;
  localparam logic [15:0] STEP = 16'h0002;
  logic clock;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic err;
  logic [2:0] pin;
  logic [1:0] fuses;
  logic [2:0] ack;
  logic [2:0] req;
  logic [15:0] vec;
  logic [15:0] vbase;
  logic irq;
  logic lo;
  logic hi;
  int bad_count;
  int comparisons;
  logic [7:0] ta [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [7:0] td [6] = '{8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'hFF};
  logic [7:0] te [6] = '{8'hE0, 8'hFF, 8'h40, 8'h80, 8'h00, 8'h07};
  eic_top #(.BOOT_BASE_0(BB0), .BOOT_BASE_2(BB2), .VECTOR_STEP(STEP)) dut
  (
    .CLOCK(clock),
    .RESET(reset),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .EXT_IRQ_PIN(pin),
    .BOOT_SIZE_FUSES(fuses),
    .IRQ_ACK(ack),
    .EXT_IRQ_REQ(req),
    .IRQ_VECTOR(vec),
    .VECTOR_BASE(vbase),
    .IRQ(irq)
  );
  eic_pin_src src
  (
    .clk(clock),
    .pin(pin)
  );
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // request held until ready is seen at an edge; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    err = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    cmp(rdata, {24'h00_0000, e});
  endtask
  task automatic ackp(input int i);
    @(posedge clock);
    ack <= 3'(1 << i);
    @(posedge clock);
    ack <= 3'h0;
  endtask
  initial
  begin
    #50us;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fuses = 2'h2;
    ack = 3'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int k = 0; k < 6; k++)
      rd(ta[k], 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      wr(ta[k], td[k]);
      rd(ta[k], te[k]);
    end
    rd(8'h14, 8'h00);
    rd(8'h1C, 8'h00);
    cmp(32'(err), 32'h0000_0001);
    $display("test registers done");
    for (int i = 0; i < 3; i++)
      for (int m = 0; m < 4; m++)
      begin
        if (i == 2 && m < 2)
          continue;
        lo = (m != 3);
        hi = (m == 1 || m == 3);
        if (i < 2)
          wr(8'h04, 8'(m << (2 * i)));
        else
          wr(8'h08, 8'((m - 2) << 6));
        src.drive(i, 1'b0, 4);
        cmp(32'(req), 32'(lo) << i);
        if (lo)
          cmp(32'(vec), 32'(STEP * 16'(i + 1)));
        ackp(i);
        src.drive(i, 1'b1, 4);
        cmp(32'(req), 32'(hi) << i);
        ackp(i);
      end
    cmp(32'(irq), 32'h0000_0001);
    wr(8'h14, 8'h07);
    rd(8'h10, 8'h00);
    cmp(32'(irq), 32'h0000_0000);
    $display("test sense modes done");
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h18, 8'h00);
    src.drive(0, 1'b0, 0);
    src.drive(1, 1'b0, 4);
    cmp(32'(req), 32'h0000_0001);
    cmp(32'(irq), 32'h0000_0000);
    wr(8'h0C, 8'h00);
    cyc(3);
    cmp(32'(req), 32'h0000_0000);
    rd(8'h10, 8'h03);
    wr(8'h18, 8'h03);
    cyc(2);
    cmp(32'(irq), 32'h0000_0001);
    src.drive(1, 1'b1, 3);
    wr(8'h14, 8'h02);
    rd(8'h10, 8'h01);
    wr(8'h0C, 8'h80);
    wr(8'h00, 8'hE0);
    cyc(3);
    cmp(32'(req), 32'h0000_0001);
    $display("test enables done");
    wr(8'h00, 8'hE1);
    cyc(1);
    cmp(32'(req), 32'h0000_0000);
    wr(8'h00, 8'hE2);
    cyc(3);
    cmp(32'(vbase), 32'(BB2));
    rd(8'h00, 8'hE2);
    rd(8'h0C, 8'h80);
    cmp(32'(req), 32'h0000_0001);
    cmp(32'(vec), 32'(BB2 + STEP));
    wr(8'h00, 8'hE1);
    cyc(8);
    rd(8'h00, 8'hE2);
    cmp(32'(req), 32'h0000_0001);
    wr(8'h00, 8'hE0);
    cyc(2);
    cmp(32'(vbase), 32'(BB2));
    @(posedge clock);
    fuses <= 2'h0;
    cyc(3);
    cmp(32'(vbase), 32'(BB0));
    wr(8'h00, 8'hE1);
    wr(8'h00, 8'hE0);
    cyc(3);
    cmp(32'(vbase), 32'h0000_0000);
    rd(8'h00, 8'hE0);
    $display("test vector select done");
    summarize();
  end
endmodule
